// File: design/lemlog_defs.svh
// Register offsets, field positions, reset values and timing figures of the limit monitor.
`ifndef LEMLOG_DEFS_SVH
`define LEMLOG_DEFS_SVH

// Byte addresses of the register words.
`define LEMLOG_ADDR_MON_CFG      8'h00
`define LEMLOG_ADDR_UPPER        8'h04
`define LEMLOG_ADDR_LOWER        8'h08
`define LEMLOG_ADDR_HYST         8'h0C
`define LEMLOG_ADDR_CNT_THRESH   8'h10
`define LEMLOG_ADDR_MON_CTRL     8'h14
`define LEMLOG_ADDR_MON_STATUS   8'h18
`define LEMLOG_ADDR_OVER_CNT     8'h1C
`define LEMLOG_ADDR_UNDER_CNT    8'h20
`define LEMLOG_ADDR_TREND_CFG    8'h24
`define LEMLOG_ADDR_TREND_IVAL   8'h28
`define LEMLOG_ADDR_TREND_CTRL   8'h2C
`define LEMLOG_ADDR_TREND_INFO   8'h30
`define LEMLOG_ADDR_TREND_START  8'h34
`define LEMLOG_ADDR_TREND_INDEX  8'h38
`define LEMLOG_ADDR_TREND_DATA   8'h3C
`define LEMLOG_ADDR_ELEC_HOURS   8'h40
`define LEMLOG_ADDR_SENS_HOURS   8'h44

// Field positions.
`define LEMLOG_MCFG_VALUE_SEL    0
`define LEMLOG_MCFG_DISPLAY_EN   1
`define LEMLOG_MCFG_ACTION_EN    2
`define LEMLOG_MCFG_IS_ALARM     3
`define LEMLOG_MCFG_OUTPUT_SEL   4
`define LEMLOG_MCTRL_ACK         0
`define LEMLOG_TCFG_NUM_LSB      0
`define LEMLOG_TCFG_MODE         2
`define LEMLOG_TCFG_SEL0         3
`define LEMLOG_TCFG_SEL1         4
`define LEMLOG_TCFG_PTS_LSB      16
`define LEMLOG_TCTRL_RESET       0
`define LEMLOG_TIDX_SEL          16
`define LEMLOG_TINFO_HALTED      31

// Trend buffer figures.
`define LEMLOG_DEPTH             735
`define LEMLOG_DROP              15

// Reset values.
`define LEMLOG_RST_NUM_VALUES    2'h1
`define LEMLOG_RST_POINTS        10'h2DF
`define LEMLOG_RST_INTERVAL      16'h0001
`define LEMLOG_RST_UPPER         16'h7FFF
`define LEMLOG_RST_LOWER         16'h8000

// Timing.
`define LEMLOG_CLK_PERIOD_NS     20
`define LEMLOG_SECOND_NS         1000000000
`define LEMLOG_HOUR_S            3600

`endif

// File: design/lemlog_pkg.sv
// Types shared by the limit monitor, trend log and hour counters.
`default_nettype none
package lemlog_pkg;

    typedef enum logic {LEMLOG_FILL_STOP, LEMLOG_OVERWRITE} lemlog_mode_e;

    typedef struct packed {
        logic [31:0]  rdata;
        logic [31:0]  cyc;
        logic [11:0]  secInHour;
        logic [31:0]  uptime;
        logic [31:0]  elecHours;
        logic [31:0]  sensHours;
        logic         sensReplaced;
        logic         valueSel;
        logic         displayEn;
        logic         actionEn;
        logic         isAlarm;
        logic         outputSel;
        logic [15:0]  upper;
        logic [15:0]  lower;
        logic [15:0]  hyst;
        logic [15:0]  cntThresh;
        logic         overArmed;
        logic         underArmed;
        logic [15:0]  overCnt;
        logic [15:0]  underCnt;
        logic         pvAlarm;
        logic         diag;
        logic         failSafe;
        logic [1:0]   numValues;
        lemlog_mode_e mode;
        logic         sel0;
        logic         sel1;
        logic [9:0]   points;
        logic [15:0]  interval;
        logic [15:0]  ivCnt;
        logic [9:0]   startPtr;
        logic [9:0]   count;
        logic         halted;
        logic [31:0]  startStamp;
        logic [9:0]   rdIdx;
        logic         rdSel;
    } lemlog_state_s;

endpackage : lemlog_pkg
`default_nettype wire

// File: design/lemlog_core.sv
// Limit monitor with event counters, two-value trend log and operating-hours counters.
//
// Design decisions made here: the address map and the strobed register port.
`default_nettype none
`include "lemlog_defs.svh"

module lemlog_core #(
    parameter logic [31:0] CYCLES_PER_SEC = `LEMLOG_SECOND_NS / `LEMLOG_CLK_PERIOD_NS,
    parameter logic [11:0] SEC_PER_HOUR   = 12'(`LEMLOG_HOUR_S),
    parameter int          DEPTH          = `LEMLOG_DEPTH
) (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        reset,
    // Register port.
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wrStrobe,
    input  wire logic        rdStrobe,
    output logic      [31:0] rdata,
    // Process values, two's complement.
    input  wire logic [15:0] pressure,
    input  wire logic [15:0] sensorTemp,
    // Device conditions.
    input  wire logic        deviceError,
    input  wire logic        sensorReplaced,
    // Status outputs.
    output logic             pvAlarm,
    output logic             diagPending,
    output logic             failSafe
);

    lemlog_pkg::lemlog_state_s s_reg;
    lemlog_pkg::lemlog_state_s s_next;

    logic [15:0] memV0 [DEPTH];
    logic [15:0] memV1 [DEPTH];

    // Modular add inside the ring; both operands are at most DEPTH.
    function automatic logic [9:0] ringAdd(input logic [9:0] a, input logic [9:0] b);
        logic [10:0] sum;
        sum = {1'b0, a} + {1'b0, b};
        if (sum >= 11'(DEPTH)) begin
            sum = sum - 11'(DEPTH);
        end
        return sum[9:0];
    endfunction : ringAdd

    logic signed [17:0] pv;
    logic signed [17:0] up;
    logic signed [17:0] lo;
    logic signed [17:0] hy;
    logic               overHit;
    logic               underHit;
    logic               ack;
    logic               trendClear;
    logic               secTick;
    logic               sampleNow;
    logic [9:0]         wrPtr;
    logic [9:0]         rdPos;
    logic [16:0]        total;
    logic [9:0]         target;
    logic               memWe;

    always_comb begin
        s_next = s_reg;
        pv = s_reg.valueSel ? 18'($signed(sensorTemp)) : 18'($signed(pressure));
        up = 18'($signed(s_reg.upper));
        lo = 18'($signed(s_reg.lower));
        hy = $signed({2'b00, s_reg.hyst});
        ack = 1'b0;
        trendClear = 1'b0;
        memWe = 1'b0;
        s_next.sensReplaced = sensorReplaced;

        // Register writes; the tool owns the monitor configuration.
        if (wrStrobe) begin
            unique case (addr)
                `LEMLOG_ADDR_MON_CFG: begin
                    s_next.valueSel  = wdata[`LEMLOG_MCFG_VALUE_SEL];
                    s_next.displayEn = wdata[`LEMLOG_MCFG_DISPLAY_EN];
                    s_next.actionEn  = wdata[`LEMLOG_MCFG_ACTION_EN];
                    s_next.isAlarm   = wdata[`LEMLOG_MCFG_IS_ALARM];
                    s_next.outputSel = wdata[`LEMLOG_MCFG_OUTPUT_SEL];
                end
                `LEMLOG_ADDR_UPPER:      s_next.upper = wdata[15:0];
                `LEMLOG_ADDR_LOWER:      s_next.lower = wdata[15:0];
                `LEMLOG_ADDR_HYST:       s_next.hyst = wdata[15:0];
                `LEMLOG_ADDR_CNT_THRESH: s_next.cntThresh = wdata[15:0];
                `LEMLOG_ADDR_MON_CTRL:   ack = wdata[`LEMLOG_MCTRL_ACK];
                `LEMLOG_ADDR_TREND_CFG: begin
                    // Out-of-range counts are clamped so the log never runs empty.
                    s_next.numValues = (wdata[1:0] == 2'h0) ? 2'h1
                                     : (wdata[1:0] == 2'h3) ? 2'h2 : wdata[1:0];
                    s_next.mode = lemlog_pkg::lemlog_mode_e'(wdata[`LEMLOG_TCFG_MODE]);
                    s_next.sel0 = wdata[`LEMLOG_TCFG_SEL0];
                    s_next.sel1 = wdata[`LEMLOG_TCFG_SEL1];
                    if (wdata[25:16] == 10'h000) begin
                        s_next.points = 10'h001;
                    end else if (wdata[25:16] > 10'(DEPTH)) begin
                        s_next.points = 10'(DEPTH);
                    end else begin
                        s_next.points = wdata[25:16];
                    end
                    trendClear = 1'b1;
                end
                `LEMLOG_ADDR_TREND_IVAL: begin
                    s_next.interval = wdata[15:0];
                    trendClear = 1'b1;
                end
                `LEMLOG_ADDR_TREND_CTRL: trendClear = wdata[`LEMLOG_TCTRL_RESET];
                `LEMLOG_ADDR_TREND_INDEX: begin
                    s_next.rdIdx = wdata[9:0];
                    s_next.rdSel = wdata[`LEMLOG_TIDX_SEL];
                end
                default: ;
            endcase
        end

        // Overrun and underrun detectors with hysteresis re-arm.
        overHit = s_reg.overArmed && (pv > up);
        if (overHit) begin
            s_next.overArmed = 1'b0;
        end else if (s_reg.hyst == 16'h0000 ? (pv <= up) : (pv < lo - hy)) begin
            s_next.overArmed = 1'b1;
        end
        underHit = s_reg.underArmed && (pv < lo);
        if (underHit) begin
            s_next.underArmed = 1'b0;
        end else if (s_reg.hyst == 16'h0000 ? (pv >= lo) : (pv > lo + hy)) begin
            s_next.underArmed = 1'b1;
        end

        // An event in the acknowledge cycle survives the clear.
        s_next.overCnt  = (ack ? 16'h0000 : s_reg.overCnt)
                        + 16'(overHit && s_reg.overCnt != 16'hFFFF);
        s_next.underCnt = (ack ? 16'h0000 : s_reg.underCnt)
                        + 16'(underHit && s_reg.underCnt != 16'hFFFF);
        total = {1'b0, s_next.overCnt} + {1'b0, s_next.underCnt};

        // Counting runs regardless of the action enable.
        s_next.diag = (s_reg.diag && !ack)
                    || (s_reg.actionEn && s_reg.cntThresh != 16'h0000
                        && total >= {1'b0, s_reg.cntThresh});
        s_next.pvAlarm = s_reg.displayEn && ((pv > up) || (pv < lo));
        // Besides a device error, only an alarm-class diagnostic on the output value may force fail-safe.
        s_next.failSafe = deviceError
                        || (s_reg.diag && s_reg.isAlarm && s_reg.outputSel == s_reg.valueSel);

        // Second and hour bases; the electronics counter has no write path.
        secTick = (s_reg.cyc >= CYCLES_PER_SEC - 32'h0000_0001);
        s_next.cyc = secTick ? 32'h0000_0000 : s_reg.cyc + 32'h0000_0001;
        if (secTick) begin
            s_next.uptime = s_reg.uptime + 32'h0000_0001;
            if (s_reg.secInHour >= SEC_PER_HOUR - 12'h001) begin
                s_next.secInHour = 12'h000;
                s_next.elecHours = s_reg.elecHours + 32'h0000_0001;
                s_next.sensHours = s_reg.sensHours + 32'h0000_0001;
            end else begin
                s_next.secInHour = s_reg.secInHour + 12'h001;
            end
        end

        // Trend sampling every interval seconds; zero acts as one.
        sampleNow = 1'b0;
        if (secTick && !s_reg.halted) begin
            if (s_reg.ivCnt + 16'h0001 >= s_reg.interval) begin
                sampleNow = 1'b1;
                s_next.ivCnt = 16'h0000;
            end else begin
                s_next.ivCnt = s_reg.ivCnt + 16'h0001;
            end
        end
        wrPtr = ringAdd(s_reg.startPtr, s_reg.count);
        target = (s_reg.mode == lemlog_pkg::LEMLOG_FILL_STOP) ? s_reg.points : 10'(DEPTH);
        if (sampleNow) begin
            memWe = 1'b1;
            if (s_reg.count + 10'h001 >= target) begin
                if (s_reg.mode == lemlog_pkg::LEMLOG_FILL_STOP) begin
                    s_next.count = s_reg.count + 10'h001;
                    s_next.halted = 1'b1;
                end else begin
                    // Full ring: the fifteen oldest make room for the next fifteen.
                    s_next.startPtr = ringAdd(s_reg.startPtr, 10'(`LEMLOG_DROP));
                    s_next.count = 10'(DEPTH - `LEMLOG_DROP + 1) - 10'h001;
                end
            end else begin
                s_next.count = s_reg.count + 10'h001;
            end
        end
        if (trendClear) begin
            s_next.startPtr = 10'h000;
            s_next.count = 10'h000;
            s_next.ivCnt = 16'h0000;
            s_next.halted = 1'b0;
            s_next.startStamp = s_reg.uptime;
        end

        // Read data appear in the cycle after the strobe; unmapped reads give zero.
        rdPos = ringAdd(s_reg.startPtr, (s_reg.rdIdx < 10'(DEPTH)) ? s_reg.rdIdx : 10'h000);
        s_next.rdata = 32'h0000_0000;
        if (rdStrobe) begin
            unique case (addr)
                `LEMLOG_ADDR_MON_CFG: s_next.rdata = {27'h000_0000, s_reg.outputSel,
                    s_reg.isAlarm, s_reg.actionEn, s_reg.displayEn, s_reg.valueSel};
                `LEMLOG_ADDR_UPPER:      s_next.rdata = {16'h0000, s_reg.upper};
                `LEMLOG_ADDR_LOWER:      s_next.rdata = {16'h0000, s_reg.lower};
                `LEMLOG_ADDR_HYST:       s_next.rdata = {16'h0000, s_reg.hyst};
                `LEMLOG_ADDR_CNT_THRESH: s_next.rdata = {16'h0000, s_reg.cntThresh};
                `LEMLOG_ADDR_MON_STATUS: s_next.rdata = {27'h000_0000, s_reg.underArmed,
                    s_reg.overArmed, s_reg.failSafe, s_reg.diag, s_reg.pvAlarm};
                `LEMLOG_ADDR_OVER_CNT:   s_next.rdata = {16'h0000, s_reg.overCnt};
                `LEMLOG_ADDR_UNDER_CNT:  s_next.rdata = {16'h0000, s_reg.underCnt};
                `LEMLOG_ADDR_TREND_CFG:  s_next.rdata = {6'h00, s_reg.points, 11'h000,
                    s_reg.sel1, s_reg.sel0, s_reg.mode, s_reg.numValues};
                `LEMLOG_ADDR_TREND_IVAL: s_next.rdata = {16'h0000, s_reg.interval};
                `LEMLOG_ADDR_TREND_INFO: s_next.rdata = {s_reg.halted, 5'h00, s_reg.count,
                    14'h0000, s_reg.numValues};
                `LEMLOG_ADDR_TREND_START: s_next.rdata = s_reg.startStamp;
                `LEMLOG_ADDR_TREND_INDEX: s_next.rdata = {15'h0000, s_reg.rdSel, 6'h00,
                    s_reg.rdIdx};
                `LEMLOG_ADDR_TREND_DATA: begin
                    if (s_reg.rdIdx < s_reg.count
                        && (!s_reg.rdSel || s_reg.numValues == 2'h2)) begin
                        s_next.rdata = {16'h0000, s_reg.rdSel ? memV1[rdPos] : memV0[rdPos]};
                    end
                end
                `LEMLOG_ADDR_ELEC_HOURS: s_next.rdata = s_reg.elecHours;
                `LEMLOG_ADDR_SENS_HOURS: s_next.rdata = s_reg.sensReplaced
                    ? s_reg.sensHours : 32'h0000_0000;
                default: ;
            endcase
        end
    end

    // The sample memory sits outside the state word; it needs no reset since count gates reads.
    always_ff @(posedge clk) begin
        if (memWe) begin
            memV0[wrPtr] <= s_reg.sel0 ? sensorTemp : pressure;
            memV1[wrPtr] <= s_reg.sel1 ? sensorTemp : pressure;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_reg            <= '0;
            s_reg.overArmed  <= 1'b1;
            s_reg.underArmed <= 1'b1;
            s_reg.upper      <= `LEMLOG_RST_UPPER;
            s_reg.lower      <= `LEMLOG_RST_LOWER;
            s_reg.numValues  <= `LEMLOG_RST_NUM_VALUES;
            s_reg.points     <= `LEMLOG_RST_POINTS;
            s_reg.interval   <= `LEMLOG_RST_INTERVAL;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rdata       = s_reg.rdata;
    assign pvAlarm     = s_reg.pvAlarm;
    assign diagPending = s_reg.diag;
    assign failSafe    = s_reg.failSafe;

endmodule : lemlog_core
`default_nettype wire

// File: tb/lemlog_checker.sv
// Port-level assertions for the limit monitor.
`default_nettype none
`include "lemlog_defs.svh"

module lemlog_checker #(
    parameter logic [31:0] CYCLES_PER_SEC = 32'h0000_000A,
    parameter logic [11:0] SEC_PER_HOUR   = 12'h004,
    parameter int          DEPTH          = `LEMLOG_DEPTH
) (
    // Clock and reset.
    input wire logic        clk,
    input wire logic        reset,
    // Register port.
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wrStrobe,
    input wire logic        rdStrobe,
    input wire logic [31:0] rdata,
    // Process values and conditions.
    input wire logic [15:0] pressure,
    input wire logic [15:0] sensorTemp,
    input wire logic        deviceError,
    input wire logic        sensorReplaced,
    // Status outputs.
    input wire logic        pvAlarm,
    input wire logic        diagPending,
    input wire logic        failSafe
);
    timeunit 1ns;
    timeprecision 1ps;
    // Shadow copies of the configuration, taken from the register writes.
    logic        [4:0]  cfg_reg;
    logic signed [15:0] up_reg;
    logic signed [15:0] lo_reg;
    logic        [1:0]  quiet_reg;
    wire logic signed [15:0] pv      = cfg_reg[0] ? sensorTemp : pressure;
    wire logic               outside = (pv > up_reg) || (pv < lo_reg);
    wire logic               ackW    = wrStrobe && addr == `LEMLOG_ADDR_MON_CTRL && wdata[0];

    always_ff @(posedge clk) begin
        if (reset) begin
            cfg_reg   <= 5'h00;
            up_reg    <= 16'h7FFF;
            lo_reg    <= 16'h8000;
            quiet_reg <= 2'h0;
        end else begin
            if (wrStrobe && addr == `LEMLOG_ADDR_MON_CFG) cfg_reg <= wdata[4:0];
            if (wrStrobe && addr == `LEMLOG_ADDR_UPPER) up_reg <= wdata[15:0];
            if (wrStrobe && addr == `LEMLOG_ADDR_LOWER) lo_reg <= wdata[15:0];
            // Saturates so that a long quiet spell never wraps back to zero.
            quiet_reg <= (cfg_reg[3] || deviceError) ? 2'h0
                       : ((quiet_reg == 2'h3) ? 2'h3 : quiet_reg + 2'h1);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    rd_idle_a: assert property (!rdStrobe |=> rdata == 32'h0000_0000)
        else $error("read data not zero outside the answer cycle");
    alarm_set_a: assert property (cfg_reg[1] && cfg_reg[2] && outside |=> pvAlarm)
        else $error("value alarm missing on a limit violation");
    alarm_clr_a: assert property (!outside |=> !pvAlarm)
        else $error("value alarm stays while value within limits");
    err_fs_a: assert property (deviceError |-> ##[1:2] failSafe)
        else $error("device error did not force fail-safe");
    alarm_fs_a: assert property (diagPending && cfg_reg[3] && cfg_reg[4] == cfg_reg[0]
        |-> ##1 failSafe)
        else $error("alarm on output value did not force fail-safe");
    warn_fs_a: assert property (quiet_reg == 2'h3 |-> !failSafe)
        else $error("fail-safe without alarm or device error");
    diag_hold_a: assert property (diagPending && !ackW |=> diagPending)
        else $error("diagnostic dropped without acknowledge");
    no_diag_a: assert property ($rose(diagPending) |-> $past(cfg_reg[2]))
        else $error("diagnostic raised while action disabled");
endmodule : lemlog_checker
`default_nettype wire

// File: tb/lemlog_tool.sv
// Engineering-tool model: register master that configures and acknowledges the monitor.
`default_nettype none
`include "lemlog_defs.svh"

module lemlog_tool (
    // Clock.
    input  wire logic        clk,
    // Register port.
    output logic      [7:0]  addr,
    output logic      [31:0] wdata,
    output logic             wrStrobe,
    output logic             rdStrobe,
    input  wire logic [31:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        addr = 8'h00;
        wdata = 32'h0000_0000;
        wrStrobe = 1'b0;
        rdStrobe = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wrStrobe <= 1'b1;
        @(posedge clk);
        wrStrobe <= 1'b0;
    endtask : wr

    // The answer is taken at the edge that closes its only valid cycle.
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge clk);
        rdStrobe <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask : rd

    task automatic configure(input logic [31:0] cfg, input logic [15:0] up, lo, hy, thr);
        wr(`LEMLOG_ADDR_MON_CFG, cfg);
        wr(`LEMLOG_ADDR_UPPER, {16'h0000, up});
        wr(`LEMLOG_ADDR_LOWER, {16'h0000, lo});
        wr(`LEMLOG_ADDR_HYST, {16'h0000, hy});
        wr(`LEMLOG_ADDR_CNT_THRESH, {16'h0000, thr});
    endtask : configure

    task automatic acknowledge;
        wr(`LEMLOG_ADDR_MON_CTRL, 32'h0000_0001);
    endtask : acknowledge
endmodule : lemlog_tool
`default_nettype wire

// File: tb/limit_event_monitor_log_test.sv
// Self-checking bench for the limit monitor, trend log and hour counters.
`default_nettype none
`include "lemlog_defs.svh"

module limit_event_monitor_log_test;
    timeunit 1ns;
    timeprecision 1ps;
    // A ten-cycle second and four-second hour keep trend and hour runs short.
    localparam logic [31:0] CPS = 32'h0000_000A;
    localparam logic [11:0] SPH = 12'h004;
    logic        clk, reset, wrStrobe, rdStrobe, deviceError, sensorReplaced;
    logic        pvAlarm, diagPending, failSafe;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, rd;
    logic [15:0] pressure, sensorTemp;
    int          mismatches, totalChecks, cyc;

    lemlog_core #(.CYCLES_PER_SEC(CPS), .SEC_PER_HOUR(SPH)) lemlog_core_inst (
        .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wrStrobe(wrStrobe),
        .rdStrobe(rdStrobe), .rdata(rdata), .pressure(pressure), .sensorTemp(sensorTemp),
        .deviceError(deviceError), .sensorReplaced(sensorReplaced), .pvAlarm(pvAlarm),
        .diagPending(diagPending), .failSafe(failSafe));
    lemlog_tool lemlog_tool_inst (.clk(clk), .addr(addr), .wdata(wdata),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdata(rdata));

    always #10 clk = ~clk;
    always @(posedge clk) if (!reset) cyc++;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : check

    task automatic checkIn(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        totalChecks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            mismatches++;
            $display("unexpected at %0t: got %h, outside %h to %h", $time, got, lo, hi);
        end
    endtask : checkIn

    task automatic pv(input logic [15:0] p);
        @(posedge clk);
        pressure <= p;
        repeat (4) @(posedge clk);
    endtask : pv

    task automatic rdCheck(input logic [7:0] a, input logic [31:0] exp);
        lemlog_tool_inst.rd(a, rd);
        check(rd, exp);
    endtask : rdCheck

    task automatic testReset;
        lemlog_tool_inst.rd(`LEMLOG_ADDR_LOWER, rd);
        check({16'h0000, rd[15:0]}, 32'h0000_8000);
        rdCheck(8'h48, 32'h0000_0000);
        lemlog_tool_inst.wr(`LEMLOG_ADDR_ELEC_HOURS, 32'h0000_FFFF);
        rdCheck(`LEMLOG_ADDR_ELEC_HOURS, 32'h0000_0000);
        rdCheck(`LEMLOG_ADDR_SENS_HOURS, 32'h0000_0000);
    endtask : testReset

    task automatic testHyst;
        logic [15:0] ov[6] = '{16'h0000, 16'h0078, 16'h003C, 16'h0078, 16'h001E, 16'h0078};
        logic [15:0] un[6] = '{16'h0046, 16'h0028, 16'h0037, 16'h0028, 16'h0046, 16'h0028};
        logic [15:0] o0[5] = '{16'h0078, 16'h0064, 16'h0078, 16'h0064, 16'h0078};
        logic [15:0] u0[5] = '{16'h0028, 16'h0032, 16'h0028, 16'h0032, 16'h0028};
        lemlog_tool_inst.configure(32'h0000_0000, 16'h0064, 16'h0032, 16'h000A, 16'h0000);
        lemlog_tool_inst.acknowledge();
        foreach (ov[i]) pv(ov[i]);
        rdCheck(`LEMLOG_ADDR_OVER_CNT, 32'h0000_0002);
        lemlog_tool_inst.acknowledge();
        foreach (un[i]) pv(un[i]);
        rdCheck(`LEMLOG_ADDR_UNDER_CNT, 32'h0000_0002);
        lemlog_tool_inst.wr(`LEMLOG_ADDR_HYST, 32'h0000_0000);
        lemlog_tool_inst.acknowledge();
        foreach (o0[i]) pv(o0[i]);
        rdCheck(`LEMLOG_ADDR_OVER_CNT, 32'h0000_0003);
        lemlog_tool_inst.acknowledge();
        foreach (u0[i]) pv(u0[i]);
        rdCheck(`LEMLOG_ADDR_UNDER_CNT, 32'h0000_0003);
    endtask : testHyst

    task automatic twoEvents;
        lemlog_tool_inst.acknowledge();
        pv(16'h0078);
        pv(16'h0040);
        pv(16'h0078);
        pv(16'h0040);
    endtask : twoEvents

    task automatic testAlarm;
        logic [31:0] cf[2] = '{32'h0000_0006, 32'h0000_001E};
        lemlog_tool_inst.configure(32'h0000_000E, 16'h0064, 16'h0032, 16'h0000, 16'h0002);
        lemlog_tool_inst.acknowledge();
        pv(16'h0078);
        check(pvAlarm, 1'b1);
        check(diagPending, 1'b0);
        pv(16'h0040);
        check(pvAlarm, 1'b0);
        pv(16'h0078);
        check(diagPending, 1'b1);
        check(failSafe, 1'b1);
        pv(16'h0040);
        check(diagPending, 1'b1);
        lemlog_tool_inst.acknowledge();
        repeat (3) @(posedge clk);
        check(diagPending, 1'b0);
        check(failSafe, 1'b0);
        rdCheck(`LEMLOG_ADDR_OVER_CNT, 32'h0000_0000);
        // A warning, and an alarm on a value not driving the output, leave it alone.
        foreach (cf[i]) begin
            lemlog_tool_inst.wr(`LEMLOG_ADDR_MON_CFG, cf[i]);
            twoEvents();
            check(diagPending, 1'b1);
            check(failSafe, 1'b0);
        end
        lemlog_tool_inst.wr(`LEMLOG_ADDR_MON_CFG, 32'h0000_0002);
        twoEvents();
        check(diagPending, 1'b0);
        rdCheck(`LEMLOG_ADDR_OVER_CNT, 32'h0000_0002);
        deviceError <= 1'b1;
        repeat (3) @(posedge clk);
        check(failSafe, 1'b1);
        deviceError <= 1'b0;
    endtask : testAlarm

    task automatic testTrend;
        @(posedge clk);
        pressure <= 16'h004D;
        sensorTemp <= 16'h0021;
        lemlog_tool_inst.wr(`LEMLOG_ADDR_TREND_CFG, 32'h0003_0013);
        lemlog_tool_inst.rd(`LEMLOG_ADDR_TREND_INFO, rd);
        checkIn({22'h00_0000, rd[25:16]}, 32'h0000_0000, 32'h0000_0001);
        repeat (100) @(posedge clk);
        rdCheck(`LEMLOG_ADDR_TREND_INFO, 32'h8003_0002);
        lemlog_tool_inst.wr(`LEMLOG_ADDR_TREND_INDEX, 32'h0001_0000);
        rdCheck(`LEMLOG_ADDR_TREND_DATA, 32'h0000_0021);
        lemlog_tool_inst.wr(`LEMLOG_ADDR_TREND_INDEX, 32'h0000_0001);
        rdCheck(`LEMLOG_ADDR_TREND_DATA, 32'h0000_004D);
        lemlog_tool_inst.wr(`LEMLOG_ADDR_TREND_INDEX, 32'h0000_0003);
        rdCheck(`LEMLOG_ADDR_TREND_DATA, 32'h0000_0000);
        lemlog_tool_inst.wr(`LEMLOG_ADDR_TREND_CFG, 32'h000A_0013);
        lemlog_tool_inst.wr(`LEMLOG_ADDR_TREND_IVAL, 32'h0000_0003);
        repeat (95) @(posedge clk);
        lemlog_tool_inst.rd(`LEMLOG_ADDR_TREND_INFO, rd);
        checkIn({22'h00_0000, rd[25:16]}, 32'h0000_0002, 32'h0000_0004);
        lemlog_tool_inst.wr(`LEMLOG_ADDR_TREND_CTRL, 32'h0000_0001);
        lemlog_tool_inst.rd(`LEMLOG_ADDR_TREND_INFO, rd);
        checkIn({22'h00_0000, rd[25:16]}, 32'h0000_0000, 32'h0000_0001);
        lemlog_tool_inst.rd(`LEMLOG_ADDR_TREND_START, rd);
        checkIn(rd, 32'(cyc / 10 - 1), 32'(cyc / 10));
        lemlog_tool_inst.wr(`LEMLOG_ADDR_TREND_IVAL, 32'h0000_0001);
        lemlog_tool_inst.wr(`LEMLOG_ADDR_TREND_CFG, 32'h02DF_0017);
        repeat (7500) @(posedge clk);
        lemlog_tool_inst.rd(`LEMLOG_ADDR_TREND_INFO, rd);
        checkIn({22'h00_0000, rd[25:16]}, 32'h0000_02D0, 32'h0000_02DF);
        check(rd[31], 1'b0);
    endtask : testTrend

    task automatic testHours;
        lemlog_tool_inst.rd(`LEMLOG_ADDR_ELEC_HOURS, rd);
        checkIn(rd, 32'(cyc / 40 - 1), 32'(cyc / 40 + 1));
        sensorReplaced <= 1'b1;
        lemlog_tool_inst.rd(`LEMLOG_ADDR_SENS_HOURS, rd);
        checkIn(rd, 32'(cyc / 40 - 1), 32'(cyc / 40 + 1));
    endtask : testHours

    task automatic conclude;
        $display("mismatches %0d, checks %0d", mismatches, totalChecks);
        if (mismatches == 0 && totalChecks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : conclude

    initial begin
        {clk, deviceError, sensorReplaced, mismatches, totalChecks, cyc} = '0;
        reset = 1'b1;
        pressure = 16'h0000;
        sensorTemp = 16'h0000;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        testReset();
        testHyst();
        testAlarm();
        testTrend();
        testHours();
        conclude();
    end

    // The whole run takes about eight thousand cycles.
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        $display("unexpected at %0t: watchdog expired", $time);
        conclude();
    end
endmodule : limit_event_monitor_log_test

bind lemlog_core lemlog_checker #(.CYCLES_PER_SEC(CYCLES_PER_SEC), .SEC_PER_HOUR(SEC_PER_HOUR),
    .DEPTH(DEPTH)) lemlog_checker_inst (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdata(rdata), .pressure(pressure),
    .sensorTemp(sensorTemp), .deviceError(deviceError), .sensorReplaced(sensorReplaced),
    .pvAlarm(pvAlarm), .diagPending(diagPending), .failSafe(failSafe));
`default_nettype wire
